// File: logic/pcrd_map.svh
// Constants of the clock driver and reset/lock logic: counts, phases, resets.
// Assumes inclusion by bare name; holds definitions only.
//
// Function
// - Double-rate clock runs at twice in-phase rate
// - One extra inverted clock at in-phase rate
// - Feedback from half in-phase rate, fixed doubling
// - Half-rate bus enable, skewed from double-rate clock
// - Loop enable low bypasses oscillator, outputs follow
// - Request high, unlocked: reset line driven low
// - Release 1024 in-phase cycles after lock
// - Request low at start-up holds line low
// - Short low request after lock: 1024-cycle reset
// - Clocks keep running locked during reset
// - Release 1024 cycles after held request rises
// - Board holds request low during slow start-up
// - Reference between 5 MHz and quarter double-rate; the model runs it at 2.5 MHz (8 clk periods of 50 ns)
`ifndef PCRD_MAP_SVH
`define PCRD_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define PCRD_CLK_PERIOD_NS     50
`define PCRD_HOLD_CYCLES       1024
`define PCRD_HOLD_WIDTH        11
`define PCRD_LOCK_REFS         4
`define PCRD_REF_MIN_MHZ       5
`define PCRD_REQ_PULSE_NS      10
`define PCRD_BOOT_HOLD_CYCLES  64
`define PCRD_REF_HALF_CYCLES   4

// ****************************************************************
// Phase counter and reset values
// ****************************************************************
`define PCRD_PHASE_WIDTH       3
`define PCRD_PHASE_RESET       3'h0
`define PCRD_ENABLE_PHASE_A    2'h0
`define PCRD_ENABLE_PHASE_B    2'h1
`define PCRD_LOCK_CNT_WIDTH    3

`endif

// File: logic/pcrd_pkg.sv
// Types used by the clock driver end of the link only.
// Assumes the constants header is available by bare name.
`include "pcrd_map.svh"
package pcrd_pkg;

  // ****************************************************************
  // Reset/lock sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    PCRD_WAIT_LOCK = 4'b0001,
    PCRD_HOLD_REQ  = 4'b0010,
    PCRD_COUNT     = 4'b0100,
    PCRD_RELEASED  = 4'b1000
  } pcrd_rst_state_t;

  typedef logic [`PCRD_PHASE_WIDTH-1:0] pcrd_phase_t;

endpackage

// File: logic/pcrd_if.sv
// Pins between the clock driver and the processor/board side.
// Assumes one clock for both ends; resolves the open-drain line with a pull-up.
`timescale 1ns/1ps
interface pcrd_if;
  logic       ref_clk;
  logic       loop_enable;
  logic       reset_request;
  logic       double_rate_clock;
  logic [2:0] inphase_clock_outputs;
  logic       inverted_phase_clock;
  logic       bus_half_rate_enable_out;
  logic       lock_out;
  logic       lock_out_oe;
  logic       lock_line;

  // Open-drain with external pull-up: low only while driven low
  assign lock_line = ~(lock_out_oe & ~lock_out);

  modport device (
    input  ref_clk,
    input  loop_enable,
    input  reset_request,
    output double_rate_clock,
    output inphase_clock_outputs,
    output inverted_phase_clock,
    output bus_half_rate_enable_out,
    output lock_out,
    output lock_out_oe,
    input  lock_line
  );

  modport board (
    output ref_clk,
    output loop_enable,
    output reset_request,
    input  double_rate_clock,
    input  inphase_clock_outputs,
    input  inverted_phase_clock,
    input  bus_half_rate_enable_out,
    input  lock_line
  );
endinterface

// File: logic/pcrd_hold_counter.sv
// Counter of in-phase output cycles that times the reset hold.
// Assumes tick is a one-cycle pulse per in-phase cycle.
`timescale 1ns/1ps
`include "pcrd_map.svh"
module pcrd_hold_counter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic clear,
  input  wire logic tick,
  // Status
  output logic      done
);
  logic [`PCRD_HOLD_WIDTH-1:0] count;
  logic [`PCRD_HOLD_WIDTH-1:0] next_count;
  logic                        next_done;

  always_comb begin
    next_count = count;
    next_done  = done;
    if (clear) begin
      next_count = '0;
      next_done  = 1'b0;
    end else if (tick && !done) begin
      if (count == `PCRD_HOLD_WIDTH'(`PCRD_HOLD_CYCLES - 1)) begin
        next_done = 1'b1;
      end else begin
        next_count = count + `PCRD_HOLD_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule

// File: logic/pcrd_device.sv
// Clock driver end: digital model of the locked clock tree, bus enable
// and the open-drain reset/lock output.
// Assumes the reference, loop enable and reset request are synchronous to clk.
// The oscillator is modelled by a phase counter stepped by clk; the
// double-rate clock toggles every rising clk edge.
`timescale 1ns/1ps
`include "pcrd_map.svh"
module pcrd_device (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link to the board and processor
  pcrd_if.device    link,
  // User-side status
  output logic      locked,
  output logic      in_reset
);

  // ****************************************************************
  // Reference edge detection
  // ****************************************************************
  logic ref_d;
  logic next_ref_d;
  logic ref_rise;

  assign ref_rise = link.ref_clk & ~ref_d;

  always_comb begin
    next_ref_d = link.ref_clk;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d <= 1'b0;
    end else begin
      ref_d <= next_ref_d;
    end
  end

  // ****************************************************************
  // Oscillator phase and lock detection
  // ****************************************************************
  // The phase counter is snapped to the reference on a miss; its top bit
  // is the internal feedback at half the in-phase rate, so with the loop
  // enabled the in-phase clock is twice the reference with no external path.
  pcrd_pkg::pcrd_phase_t           phase;
  pcrd_pkg::pcrd_phase_t           next_phase;
  logic [`PCRD_LOCK_CNT_WIDTH-1:0] lock_cnt;
  logic [`PCRD_LOCK_CNT_WIDTH-1:0] next_lock_cnt;
  logic                            next_locked;

  always_comb begin
    next_phase    = phase + `PCRD_PHASE_WIDTH'(1);
    next_lock_cnt = lock_cnt;
    next_locked   = locked;
    if (!link.loop_enable) begin
      // Oscillator stopped: lock is not meaningful, treated as reached
      next_phase    = `PCRD_PHASE_RESET;
      next_lock_cnt = '0;
      next_locked   = 1'b1;
    end else if (ref_rise) begin
      if (phase == `PCRD_PHASE_RESET) begin
        if (lock_cnt == `PCRD_LOCK_CNT_WIDTH'(`PCRD_LOCK_REFS - 1)) begin
          next_locked = 1'b1;
        end else begin
          next_lock_cnt = lock_cnt + `PCRD_LOCK_CNT_WIDTH'(1);
        end
      end else begin
        // Feedback edge missed the reference: correct and relock
        next_phase    = `PCRD_PHASE_WIDTH'(1);
        next_lock_cnt = '0;
        next_locked   = 1'b0;
      end
    end else if (link.loop_enable && locked && ref_d == 1'b0 && phase == `PCRD_PHASE_RESET) begin
      // Feedback fell with no reference edge: the reference is gone
      next_lock_cnt = '0;
      next_locked   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= `PCRD_PHASE_RESET;
      lock_cnt <= '0;
      locked   <= 1'b0;
    end else begin
      phase    <= next_phase;
      lock_cnt <= next_lock_cnt;
      locked   <= next_locked;
    end
  end

  // ****************************************************************
  // Clock outputs
  // ****************************************************************
  // All outputs are registered from the same phase (from the reference in test mode) so they stay in step;
  // they never stop for the reset sequence.
  logic       dbl_clk;
  logic       next_dbl_clk;
  logic [2:0] iph_clk;
  logic [2:0] next_iph_clk;
  logic       inv_clk;
  logic       next_inv_clk;
  logic       bus_en;
  logic       next_bus_en;
  logic       iph_tick;

  always_comb begin
    if (link.loop_enable) begin
      next_dbl_clk = next_phase[0];
      next_iph_clk = {3{next_phase[1]}};
      next_inv_clk = ~next_phase[1];
      // High across the double-rate edge one half-period late, so the
      // processor enable has setup and hold around its sampling edge
      next_bus_en  = (next_phase[1:0] == `PCRD_ENABLE_PHASE_A) ||
                     (next_phase[1:0] == `PCRD_ENABLE_PHASE_B);
    end else begin
      // Static test mode: outputs follow the reference, no frequency limit
      next_dbl_clk = link.ref_clk;
      next_iph_clk = {3{link.ref_clk}};
      next_inv_clk = ~link.ref_clk;
      next_bus_en  = link.ref_clk;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbl_clk <= 1'b0;
      iph_clk <= 3'h0;
      inv_clk <= 1'b1;
      bus_en  <= 1'b0;
    end else begin
      dbl_clk <= next_dbl_clk;
      iph_clk <= next_iph_clk;
      inv_clk <= next_inv_clk;
      bus_en  <= next_bus_en;
    end
  end

  assign link.double_rate_clock        = dbl_clk;
  assign link.inphase_clock_outputs    = iph_clk;
  assign link.inverted_phase_clock     = inv_clk;
  assign link.bus_half_rate_enable_out = bus_en;

  // One tick per in-phase cycle, at its rising edge
  assign iph_tick = next_iph_clk[0] & ~iph_clk[0];

  // ****************************************************************
  // Reset/lock sequencer
  // ****************************************************************
  pcrd_pkg::pcrd_rst_state_t state;
  pcrd_pkg::pcrd_rst_state_t next_state;
  logic                      hold_clear;
  logic                      hold_done;
  logic                      next_in_reset;
  logic                      drive_low;
  logic                      next_drive_low;

  always_comb begin
    next_state = state;
    hold_clear = 1'b0;
    case (state)
      pcrd_pkg::PCRD_WAIT_LOCK: begin
        hold_clear = 1'b1;
        if (!link.reset_request) begin
          next_state = pcrd_pkg::PCRD_HOLD_REQ;
        end else if (locked) begin
          next_state = pcrd_pkg::PCRD_COUNT;
        end
      end
      pcrd_pkg::PCRD_HOLD_REQ: begin
        hold_clear = 1'b1;
        if (link.reset_request) begin
          next_state = locked ? pcrd_pkg::PCRD_COUNT : pcrd_pkg::PCRD_WAIT_LOCK;
        end
      end
      pcrd_pkg::PCRD_COUNT: begin
        if (!link.reset_request) begin
          hold_clear = 1'b1;
          next_state = pcrd_pkg::PCRD_HOLD_REQ;
        end else if (!locked) begin
          next_state = pcrd_pkg::PCRD_WAIT_LOCK;
        end else if (hold_done) begin
          next_state = pcrd_pkg::PCRD_RELEASED;
        end
      end
      pcrd_pkg::PCRD_RELEASED: begin
        hold_clear = 1'b1;
        if (!link.reset_request) begin
          next_state = pcrd_pkg::PCRD_HOLD_REQ;
        end else if (!locked) begin
          next_state = pcrd_pkg::PCRD_WAIT_LOCK;
        end
      end
      default: begin
        hold_clear = 1'b1;
        next_state = pcrd_pkg::PCRD_WAIT_LOCK;
      end
    endcase
    next_drive_low = (next_state != pcrd_pkg::PCRD_RELEASED);
    next_in_reset  = next_drive_low;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= pcrd_pkg::PCRD_WAIT_LOCK;
      drive_low <= 1'b1;
      in_reset  <= 1'b1;
    end else begin
      state     <= next_state;
      drive_low <= next_drive_low;
      in_reset  <= next_in_reset;
    end
  end

  // In test mode a tick is one reference cycle, which the outputs follow
  pcrd_hold_counter u_hold (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (hold_clear),
    .tick  (iph_tick),
    .done  (hold_done)
  );

  // Open-drain: the pin is only ever pulled low, never driven high
  assign link.lock_out    = 1'b0;
  assign link.lock_out_oe = drive_low;

endmodule

// File: logic/pcrd_board.sv
// Board and processor end: makes the reference, loop enable and reset
// request, and takes the processor reset and clock enable.
// Assumes the same clk as the driver end; link inputs are synchronous.
`timescale 1ns/1ps
`include "pcrd_map.svh"
module pcrd_board (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link to the clock driver
  pcrd_if.board     link,
  // User side
  input  wire logic test_mode,
  input  wire logic reset_pulse,
  input  wire logic hold_reset,
  output logic      cpu_reset_n,
  output logic      processor_clock_enable_in
);
  localparam int PULSE_CYCLES = (`PCRD_REQ_PULSE_NS + `PCRD_CLK_PERIOD_NS - 1) / `PCRD_CLK_PERIOD_NS;
  localparam int PULSE_MIN    = (PULSE_CYCLES < 1) ? 1 : PULSE_CYCLES;

  logic [2:0] ref_div;
  logic [2:0] next_ref_div;
  logic       ref_clk;
  logic       next_ref_clk;
  logic [6:0] boot_cnt;
  logic [6:0] next_boot_cnt;
  logic [2:0] pulse_cnt;
  logic [2:0] next_pulse_cnt;
  logic       req;
  logic       next_req;
  logic       loop_en;
  logic       next_loop_en;
  logic       next_cpu_reset_n;
  logic       next_clk_en;

  always_comb begin
    // Reference at a quarter of the double-rate clock
    next_ref_div = ref_div + 3'h1;
    next_ref_clk = ref_clk;
    if (ref_div == 3'(`PCRD_REF_HALF_CYCLES - 1)) begin
      next_ref_div = 3'h0;
      next_ref_clk = ~ref_clk;
    end
    // Request held low through start-up, so reset never hangs on lock time
    next_boot_cnt = boot_cnt;
    if (boot_cnt != 7'(`PCRD_BOOT_HOLD_CYCLES)) begin
      next_boot_cnt = boot_cnt + 7'h1;
    end
    next_pulse_cnt = (pulse_cnt != 3'h0) ? pulse_cnt - 3'h1 : 3'h0;
    if (reset_pulse) begin
      next_pulse_cnt = 3'(PULSE_MIN);
    end
    next_req = !(hold_reset || next_pulse_cnt != 3'h0 ||
                 next_boot_cnt != 7'(`PCRD_BOOT_HOLD_CYCLES));
    next_loop_en     = ~test_mode;
    next_cpu_reset_n = link.lock_line;
    next_clk_en      = link.bus_half_rate_enable_out;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_div                   <= 3'h0;
      ref_clk                   <= 1'b0;
      boot_cnt                  <= 7'h0;
      pulse_cnt                 <= 3'h0;
      req                       <= 1'b0;
      loop_en                   <= 1'b1;
      cpu_reset_n               <= 1'b0;
      processor_clock_enable_in <= 1'b0;
    end else begin
      ref_div                   <= next_ref_div;
      ref_clk                   <= next_ref_clk;
      boot_cnt                  <= next_boot_cnt;
      pulse_cnt                 <= next_pulse_cnt;
      req                       <= next_req;
      loop_en                   <= next_loop_en;
      cpu_reset_n               <= next_cpu_reset_n;
      processor_clock_enable_in <= next_clk_en;
    end
  end

  assign link.ref_clk       = ref_clk;
  assign link.loop_enable   = loop_en;
  assign link.reset_request = req;
endmodule

// File: verif/pcrd_chk.sv
// Checker for the clock driver link: clock ratios, enable skew, reset/lock line.
// Assumes the plain interface signals and one clock domain.
`timescale 1ns/1ps
module pcrd_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link signals
  input wire logic       ref_clk,
  input wire logic       loop_enable,
  input wire logic       reset_request,
  input wire logic       double_rate_clock,
  input wire logic [2:0] inphase_clock_outputs,
  input wire logic       inverted_phase_clock,
  input wire logic       bus_half_rate_enable_out,
  input wire logic       lock_out_oe,
  input wire logic       lock_line
);
  // ****************
  // Tick counter
  // ****************
  logic [11:0] ticks;
  logic [11:0] next_ticks;
  logic        seen;
  logic        next_seen;
  logic        iph_q;
  logic        next_iph_q;

  // Restarts on every low request, so it also times a restarted hold
  always_comb begin
    next_seen = seen | lock_line;
    next_iph_q = inphase_clock_outputs[0];
    next_ticks = ticks;
    if (!reset_request) begin
      next_ticks = 12'h000;
    end else if (inphase_clock_outputs[0] & ~iph_q & (ticks != 12'hfff)) begin
      next_ticks = ticks + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks <= 12'h000;
      seen <= 1'b0;
      iph_q <= 1'b0;
    end else begin
      ticks <= next_ticks;
      seen <= next_seen;
      iph_q <= next_iph_q;
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_inverted_pair: assert property (inverted_phase_clock == ~inphase_clock_outputs[0])
    else $error("inverted clock is not the complement");
  chk_outputs_aligned: assert property (inphase_clock_outputs == {3{inphase_clock_outputs[0]}})
    else $error("in-phase outputs differ");
  chk_double_toggles: assert property (loop_enable [*3] |-> double_rate_clock != $past(double_rate_clock))
    else $error("double-rate clock missed a toggle");
  chk_inphase_period: assert property ((seen && loop_enable) [*5] ##0 $rose(inphase_clock_outputs[0])
    |-> $past(inphase_clock_outputs[0], 3) && $past(inphase_clock_outputs[0], 4)
        && !$past(inphase_clock_outputs[0], 2))
    else $error("in-phase period is not four cycles");
  chk_enable_skew: assert property ((seen && loop_enable) [*5] ##0 $rose(bus_half_rate_enable_out)
    |-> $past(bus_half_rate_enable_out, 3) && $past(bus_half_rate_enable_out, 4)
        && !$past(bus_half_rate_enable_out, 2) && !$rose(inphase_clock_outputs[0])
        && !$rose(double_rate_clock))
    else $error("bus enable not half rate or not skewed");
  // The enable must never change on a double-rate rising edge, or the
  // processor sees it inside its setup or hold window
  chk_enable_hold: assert property ((seen && loop_enable) [*3] ##0 $fell(bus_half_rate_enable_out)
    |-> !$rose(double_rate_clock))
    else $error("bus enable fell on a double-rate rising edge");
  chk_request_low: assert property (!reset_request |=> lock_out_oe)
    else $error("request low did not pull the line");
  chk_open_drain: assert property (lock_line == !lock_out_oe)
    else $error("line level disagrees with enable");
  chk_release_count: assert property ($fell(lock_out_oe) |-> ticks >= 12'h3ff && ticks <= 12'h401)
    else $error("release not after 1024 in-phase cycles");
  chk_test_follows: assert property (!loop_enable && !$past(loop_enable)
    |-> inphase_clock_outputs[0] == $past(ref_clk))
    else $error("test mode output does not follow reference");
endmodule

// File: verif/testbench.sv
// Self-checking bench: driver end facing board end, user sides driven in a fixed order with random lengths.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`include "pcrd_map.svh"
module testbench;
  logic clk;
  logic rst_n;
  logic test_mode;
  logic reset_pulse;
  logic hold_reset;
  logic locked;
  logic in_reset;
  logic cpu_reset_n;
  logic cpu_clk_en;
  logic prev_ref;
  int   n_errors;
  int   cmp_count;
  int   seed;
  int   i;
  int   nt;
  int   nd;
  int   nr;
  int   ne;

  pcrd_if link ();
  pcrd_device u_pcrd_device (.clk(clk), .rst_n(rst_n), .link(link), .locked(locked), .in_reset(in_reset));
  pcrd_board u_pcrd_board (.clk(clk), .rst_n(rst_n), .link(link), .test_mode(test_mode),
    .reset_pulse(reset_pulse), .hold_reset(hold_reset), .cpu_reset_n(cpu_reset_n),
    .processor_clock_enable_in(cpu_clk_en));
  pcrd_chk u_pcrd_chk (.clk(clk), .rst_n(rst_n), .ref_clk(link.ref_clk), .loop_enable(link.loop_enable),
    .reset_request(link.reset_request), .double_rate_clock(link.double_rate_clock),
    .inphase_clock_outputs(link.inphase_clock_outputs), .inverted_phase_clock(link.inverted_phase_clock),
    .bus_half_rate_enable_out(link.bus_half_rate_enable_out), .lock_out_oe(link.lock_out_oe),
    .lock_line(link.lock_line));

  // ****************
  // Tasks
  // ****************
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Expected figures of one hold, from the hold length and the fixed ratios
  function automatic int exp_hold();
    return `PCRD_HOLD_CYCLES;
  endfunction

  function automatic int exp_scaled(input int base, input int num, input int den);
    return base * num / den;
  endfunction

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts are bench-made, so a small pipeline slack is allowed
  task automatic cmp_near(input int got, input int exp, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse();
    reset_pulse = 1'b1;
    step(1 + {$random(seed)} % 3);
    reset_pulse = 1'b0;
  endtask

  // Edges seen from request rise to line release
  task automatic measure(output int t, output int d, output int r, output int e);
    int   k;
    logic pi;
    logic pd;
    logic pr;
    logic pe;
    t = 0;
    d = 0;
    r = 0;
    e = 0;
    k = 0;
    while (link.reset_request !== 1'b1 || link.lock_line !== 1'b1) begin
      pi = link.inphase_clock_outputs[0];
      pd = link.double_rate_clock;
      pr = link.ref_clk;
      pe = cpu_clk_en;
      @(negedge clk);
      k++;
      if (link.reset_request === 1'b1) begin
        t += (link.inphase_clock_outputs[0] === 1'b1 && pi === 1'b0);
        d += (link.double_rate_clock === 1'b1 && pd === 1'b0);
        r += (link.ref_clk === 1'b1 && pr === 1'b0);
        e += (cpu_clk_en === 1'b1 && pe === 1'b0);
      end
      if (k > 9000) begin
        n_errors++;
        $display("Error at %0t: got %h expected %h", $time, link.lock_line, 1'b1);
        test_done();
      end
    end
    cmp_near(t, exp_hold(), 1);
    cmp_near(d, exp_scaled(t, 2, 1), 2);
    cmp_near(2 * r, t, 2);
    cmp_near(e, t, 2);
    step(2);
    cmp_bit(cpu_reset_n, 1'b1);
    cmp_bit(in_reset, 1'b0);
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    test_mode = 1'b0;
    reset_pulse = 1'b0;
    hold_reset = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    seed = 32'h04c3_a440;
    step(8);
    rst_n = 1'b1;
    step(60);
    cmp_bit(link.lock_line, 1'b0);
    cmp_bit(locked, 1'b1);
    measure(nt, nd, nr, ne);
    for (i = 0; i < 6; i++) begin
      case (i % 3)
        0: begin
          pulse();
          step(2);
          cmp_bit(in_reset, 1'b1);
        end
        1: begin
          hold_reset = 1'b1;
          step(50 + {$random(seed)} % 250);
          cmp_bit(link.lock_line, 1'b0);
          cmp_bit(cpu_reset_n, 1'b0);
          hold_reset = 1'b0;
        end
        default: begin
          pulse();
          step(100 + {$random(seed)} % 1900);
          cmp_bit(link.lock_line, 1'b0);
          pulse();
        end
      endcase
      measure(nt, nd, nr, ne);
    end
    // Test mode last: the loop is not brought back up afterwards
    test_mode = 1'b1;
    step(20);
    cmp_bit(locked, 1'b1);
    for (i = 0; i < 24; i++) begin
      prev_ref = link.ref_clk;
      step(1);
      cmp_bit(link.inphase_clock_outputs[0], prev_ref);
    end
    test_done();
  end
endmodule
